/* File: pkg/scb_pkg.sv */
/*
 * Shared constants for the serial configuration bitstream source and its
 * target-side sequencer. Assumes a single 250 MHz system clock per end.
 */
`default_nettype none

package scb_pkg;

	// System clock rate
	localparam int SYS_CLK_MHZ = 250;

	// Power-on hold-off, a longest time, rounded down
	localparam int POR_DELAY_MS = 200;
	localparam int POR_CYCLES = POR_DELAY_MS * 1000 * SYS_CLK_MHZ;

	// Least enable-low pulse for a counter reset, rounded up
	localparam int OE_LOW_NS = 100;
	localparam int OE_LOW_CYCLES = (OE_LOW_NS * SYS_CLK_MHZ + 999) / 1000;

	// Least shift clock high and low time, rounded up
	localparam int SHIFT_HALF_NS = 40;
	localparam int SHIFT_HALF_CYCLES =
		(SHIFT_HALF_NS * SYS_CLK_MHZ + 999) / 1000;

	// Stored bitstream length
	localparam int MEM_BITS = 1024;

	// Width of the target's phase counter
	localparam int PHASE_W = 8;

	// Reset values
	localparam logic [2:0] SYNC_RESET = 3'h1; // clk 0, enable 0, cs_n 1

	// Device end sequencing
	typedef enum logic [1:0] {
		DEV_POR = 2'h0,
		DEV_RUN = 2'h1,
		DEV_DONE = 2'h2
	} scb_dev_state_e;

	// Target end sequencing
	typedef enum logic [2:0] {
		TGT_IDLE = 3'h0,
		TGT_RESET = 3'h1,
		TGT_WAIT = 3'h2,
		TGT_LOW = 3'h3,
		TGT_HIGH = 3'h4,
		TGT_DONE = 3'h5
	} scb_tgt_state_e;

endpackage

`default_nettype wire

/* File: pkg/scb_link_if.sv */
/*
 * Link between the bitstream source and the target sequencer.
 * Resolves the open-drain enable line (pulled up) and the data line,
 * which floats high through a pull-up while nobody drives it.
 */
`default_nettype none

interface scb_link_if;
	// Shift clock, made by the target
	logic shift_clock;
	// Chip select into the source, active low
	logic chip_select_n;
	// Cascade select out of the source, active low
	logic cascade_select_n;
	// Open-drain enable/reset drivers of both ends
	logic dev_oe_out;
	logic dev_oe_en;
	logic tgt_oe_out;
	logic tgt_oe_en;
	// Serial data driver of the source
	logic data_out;
	logic data_en;
	// Resolved wire levels
	logic oe_level;
	logic target_serial_input;

	// Any end pulling low wins over the pull-up
	assign oe_level = !((dev_oe_en && !dev_oe_out) ||
		(tgt_oe_en && !tgt_oe_out));
	// Pull-up when the source releases the data line
	assign target_serial_input = data_en ? data_out : 1'b1;

	// Source end
	modport dev (
		input shift_clock,
		input chip_select_n,
		input oe_level,
		output dev_oe_out,
		output dev_oe_en,
		output data_out,
		output data_en,
		output cascade_select_n
	);

	// Target end
	modport tgt (
		output shift_clock,
		output chip_select_n,
		output tgt_oe_out,
		output tgt_oe_en,
		input oe_level,
		input target_serial_input,
		input cascade_select_n
	);
endinterface

`default_nettype wire

/* File: rtl/scb_device.sv */
/*
 * Serial configuration bitstream source: stores a bitstream and shifts
 * it out one bit per rising shift clock edge. Assumes the link pins are
 * asynchronous to sys_clk and that the shift clock half period spans
 * several sys_clk cycles.
 */
`default_nettype none

module scb_device #(
	parameter int MEM_BITS = scb_pkg::MEM_BITS,
	parameter int POR_CYCLES = scb_pkg::POR_CYCLES,
	parameter bit CASCADE_EN = 1'b1,
	parameter int AW = $clog2(MEM_BITS)
) (
	// System
	input wire logic sys_clk,
	input wire logic reset,
	// Link to the target
	scb_link_if.dev link,
	// Bitstream load port
	input wire logic load_en,
	input wire logic [AW-1:0] load_addr,
	input wire logic load_bit,
	// Status
	output logic por_busy,
	output logic sending,
	output logic sent_all
);

	// Power-on counter width
	localparam int PCW = $clog2(POR_CYCLES + 1);

	// Stored bitstream, filled through the load port
	logic mem [MEM_BITS];

	// Synchroniser stages: {shift clock, enable, chip select}
	logic [2:0] meta_reg;
	logic [2:0] sync_reg;
	// Previous synchronised shift clock
	logic clk_prev_reg;

	// Sequencing
	scb_pkg::scb_dev_state_e state_reg;
	scb_pkg::scb_dev_state_e state_next;
	logic [PCW-1:0] por_cnt_reg;
	logic [AW-1:0] addr_reg;

	// Pin-side registers
	logic data_reg;
	logic data_en_reg;
	logic oe_drive_reg;
	logic casc_n_reg;

	// Decoded conditions
	logic clk_s;
	logic oe_s;
	logic cs_n_s;
	logic rise;
	logic advance;
	logic last_bit;
	logic por_end;

	assign clk_s = sync_reg[2];
	assign oe_s = sync_reg[1];
	assign cs_n_s = sync_reg[0];

	// Rising edge seen on the second stage only
	assign rise = clk_s && !clk_prev_reg;

	// Count only while enabled, selected and unfinished
	assign advance = (state_reg == scb_pkg::DEV_RUN) && oe_s &&
		!cs_n_s && rise;

	// Counter sits on the final stored bit
	assign last_bit = (addr_reg == AW'(MEM_BITS - 1));

	// Hold-off expires
	assign por_end = (por_cnt_reg == PCW'(POR_CYCLES - 1));

	// Bitstream storage write
	always_ff @(posedge sys_clk) begin
		if (load_en) begin
			mem[load_addr] <= load_bit;
		end
	end

	// Two-stage synchroniser for all link inputs
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			meta_reg <= scb_pkg::SYNC_RESET;
			sync_reg <= scb_pkg::SYNC_RESET;
		end else begin
			meta_reg <= {link.shift_clock, link.oe_level,
				link.chip_select_n};
			sync_reg <= meta_reg;
		end
	end

	// Edge detector history
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			clk_prev_reg <= 1'b0;
		end else begin
			clk_prev_reg <= clk_s;
		end
	end

	// Power-on hold-off counter; runs once after reset only
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			por_cnt_reg <= '0;
		end else if (state_reg == scb_pkg::DEV_POR) begin
			por_cnt_reg <= por_cnt_reg + PCW'(1);
		end
	end

	// Next state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			// Only a system reset, or the unused state code, brings us back here
			scb_pkg::DEV_POR: begin
				if (por_end) begin
					state_next = scb_pkg::DEV_RUN;
				end
			end
			// Shifting, or waiting for enable and select
			scb_pkg::DEV_RUN: begin
				if (advance && last_bit) begin
					state_next = scb_pkg::DEV_DONE;
				end
			end
			// All sent; a low enable starts over, no hold-off
			scb_pkg::DEV_DONE: begin
				if (!oe_s) begin
					state_next = scb_pkg::DEV_RUN;
				end
			end
			default: begin
				state_next = scb_pkg::DEV_POR;
			end
		endcase
	end

	// State register
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_reg <= scb_pkg::DEV_POR;
		end else begin
			state_reg <= state_next;
		end
	end

	// Address counter
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			addr_reg <= '0;
		end else if (!oe_s) begin
			// Low enable clears, even mid-stream
			addr_reg <= '0;
		end else if (advance && !last_bit) begin
			addr_reg <= addr_reg + AW'(1);
		end
	end

	// Present the addressed bit; held after the last edge
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			data_reg <= 1'b0;
		end else begin
			data_reg <= mem[addr_reg];
		end
	end

	// Data driver enable: released before start, when deselected
	// and after the final bit, wherever we sit in a chain
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			data_en_reg <= 1'b0;
		end else begin
			data_en_reg <= (state_next == scb_pkg::DEV_RUN) &&
				oe_s && !cs_n_s;
		end
	end

	// Pull the enable line low during the hold-off; never drive it high
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			oe_drive_reg <= 1'b1;
		end else begin
			oe_drive_reg <= (state_next == scb_pkg::DEV_POR);
		end
	end

	// Cascade select: low once a rising edge comes with the counter at its maximum.
	// Non-cascading builds keep it high so a chain cannot advance.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			casc_n_reg <= 1'b1;
		end else begin
			casc_n_reg <= !(CASCADE_EN &&
				(state_next == scb_pkg::DEV_DONE));
		end
	end

	// Status flags
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			por_busy <= 1'b1;
			sending <= 1'b0;
			sent_all <= 1'b0;
		end else begin
			por_busy <= (state_next == scb_pkg::DEV_POR);
			sending <= (state_next == scb_pkg::DEV_RUN) && oe_s &&
				!cs_n_s;
			sent_all <= (state_next == scb_pkg::DEV_DONE);
		end
	end

	// Link drivers: open-drain enable only ever pulls low
	assign link.dev_oe_out = 1'b0;
	assign link.dev_oe_en = oe_drive_reg;
	assign link.data_out = data_reg;
	assign link.data_en = data_en_reg;
	// Next device in a chain takes this as its chip select
	assign link.cascade_select_n = casc_n_reg;

endmodule // scb_device

`default_nettype wire

/* File: rtl/scb_target.sv */
/*
 * Target-side configuration sequencer: pulses the enable/reset line,
 * makes the shift clock by dividing sys_clk and collects the serial
 * stream. Assumes the source answers within one shift clock low phase.
 */
`default_nettype none

module scb_target #(
	parameter int TOTAL_BITS = scb_pkg::MEM_BITS,
	parameter bit LEGACY_MODE = 1'b1,
	parameter int BW = $clog2(TOTAL_BITS + 1)
) (
	// System
	input wire logic sys_clk,
	input wire logic reset,
	// Link to the source
	scb_link_if.tgt link,
	// Control
	input wire logic start,
	// Received stream
	output logic rx_valid,
	output logic rx_bit,
	// Status
	output logic busy,
	output logic config_done
);

	localparam int PW = scb_pkg::PHASE_W;

	// Synchroniser stages: {enable level, serial data}
	logic [1:0] meta_reg;
	logic [1:0] sync_reg;

	// Sequencing
	scb_pkg::scb_tgt_state_e state_reg;
	logic [PW-1:0] phase_reg;
	logic [BW-1:0] bits_reg;

	// Pin-side registers
	logic clk_reg;
	logic cs_n_reg;

	// Phase ends
	logic reset_end;
	logic half_end;

	assign reset_end = (phase_reg == PW'(scb_pkg::OE_LOW_CYCLES - 1));
	assign half_end = (phase_reg == PW'(scb_pkg::SHIFT_HALF_CYCLES - 1));

	// Two-stage synchroniser for the link inputs
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			meta_reg <= 2'h0;
			sync_reg <= 2'h0;
		end else begin
			meta_reg <= {link.oe_level, link.target_serial_input};
			sync_reg <= meta_reg;
		end
	end

	// Sequencer, phase counter and clock divider
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_reg <= scb_pkg::TGT_IDLE;
			phase_reg <= '0;
			bits_reg <= '0;
			clk_reg <= 1'b0;
		end else begin
			phase_reg <= phase_reg + PW'(1);
			case (state_reg)
				// Waiting for a request
				scb_pkg::TGT_IDLE, scb_pkg::TGT_DONE: begin
					clk_reg <= 1'b0;
					if (start) begin
						state_reg <= scb_pkg::TGT_RESET;
						phase_reg <= '0;
						bits_reg <= '0;
					end
				end
				// Enable held low long enough to clear the counter
				scb_pkg::TGT_RESET: begin
					if (reset_end) begin
						state_reg <= scb_pkg::TGT_WAIT;
					end
				end
				// Source may still be in its hold-off
				scb_pkg::TGT_WAIT: begin
					phase_reg <= '0;
					if (sync_reg[1]) begin
						state_reg <= scb_pkg::TGT_LOW;
					end
				end
				// Low half; sample just before the rising edge
				scb_pkg::TGT_LOW: begin
					if (half_end) begin
						clk_reg <= 1'b1;
						phase_reg <= '0;
						bits_reg <= bits_reg + BW'(1);
						state_reg <= scb_pkg::TGT_HIGH;
					end
				end
				// High half
				scb_pkg::TGT_HIGH: begin
					if (half_end) begin
						clk_reg <= 1'b0;
						phase_reg <= '0;
						if (bits_reg == BW'(TOTAL_BITS)) begin
							state_reg <= scb_pkg::TGT_DONE;
						end else begin
							state_reg <= scb_pkg::TGT_LOW;
						end
					end
				end
				default: begin
					state_reg <= scb_pkg::TGT_IDLE;
					clk_reg <= 1'b0;
				end
			endcase
		end
	end

	// Received bit strobe, taken from the synchronised data line
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rx_valid <= 1'b0;
			rx_bit <= 1'b0;
		end else begin
			rx_valid <= (state_reg == scb_pkg::TGT_LOW) && half_end;
			if ((state_reg == scb_pkg::TGT_LOW) && half_end) begin
				rx_bit <= sync_reg[0];
			end
		end
	end

	// Chip select asserted from the reset pulse until done
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cs_n_reg <= 1'b1;
			busy <= 1'b0;
			config_done <= 1'b0;
		end else begin
			cs_n_reg <= (state_reg == scb_pkg::TGT_IDLE) ||
				(state_reg == scb_pkg::TGT_DONE);
			busy <= (state_reg != scb_pkg::TGT_IDLE) &&
				(state_reg != scb_pkg::TGT_DONE);
			config_done <= (state_reg == scb_pkg::TGT_DONE);
		end
	end

	// Enable line: pull low in the reset phase; in legacy mode drive
	// it high while configuring (a low from the source still wins)
	assign link.tgt_oe_out = (state_reg != scb_pkg::TGT_RESET);
	assign link.tgt_oe_en = (state_reg == scb_pkg::TGT_RESET) ||
		(LEGACY_MODE && busy);
	assign link.shift_clock = clk_reg;
	assign link.chip_select_n = cs_n_reg;

endmodule // scb_target

`default_nettype wire

/* File: tb/scb_props.sv */
/*
 * Link checker for the source/target pair.
 * Assumes one sys_clk domain and the resolved link wires as inputs.
 */
`default_nettype none

module scb_props #(
	parameter int MEM_BITS = 16
) (
	// System
	input wire logic sys_clk,
	input wire logic reset,
	// Link wires
	input wire logic shift_clock,
	input wire logic chip_select_n,
	input wire logic cascade_select_n,
	input wire logic dev_oe_out,
	input wire logic dev_oe_en,
	input wire logic data_out,
	input wire logic data_en,
	input wire logic oe_level
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	int rise_cnt; // Rises seen since the line went low
	logic clk_prev; // Last sampled shift clock

	// Mirrors the source address so cascade timing can be judged
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rise_cnt <= 0;
			clk_prev <= 1'b0;
		end else begin
			clk_prev <= shift_clock;
			// Line low wipes the count, as it wipes the address
			if (!oe_level) begin
				rise_cnt <= 0;
			end else if (shift_clock && !clk_prev) begin
				rise_cnt <= rise_cnt + 1;
			end
		end
	end

	a_por_hold_line: assert property ($fell(reset) |->
		!oe_level[*8] ##[1:40] oe_level) else $error("hold-off wrong");
	a_data_off_deselect: assert property (chip_select_n[*4] |->
		!data_en) else $error("data driven while deselected");
	a_data_off_reset: assert property (!oe_level[*4] |-> !data_en)
		else $error("data driven while line low");
	a_data_on_cause: assert property ($rose(data_en) |->
		$past(oe_level, 2) && !$past(chip_select_n, 2))
		else $error("data enabled without cause");
	a_casc_at_max: assert property ($fell(cascade_select_n) |->
		rise_cnt == MEM_BITS) else $error("cascade at wrong count");
	a_casc_clear_low: assert property (!oe_level[*6] |->
		cascade_select_n) else $error("cascade kept after reset");
	a_data_steady_low: assert property (data_en && $past(data_en) &&
		!shift_clock && !$past(shift_clock) |-> $stable(data_out))
		else $error("data moved in low phase");
	a_oe_open_drain: assert property (dev_oe_en |-> !dev_oe_out)
		else $error("enable line driven high");

	// Main scenarios
	cover property ($fell(cascade_select_n));
	cover property ($rose(data_en));
	cover property ($fell(oe_level) ##1 !oe_level[*8]);
endmodule // scb_props

`default_nettype wire

/* File: tb/serial_config_bitstream_source_tb.sv */
/*
 * Bench: source and target joined on one link, and a second source
 * (no cascade) driven directly by the bench on a 32 ns shift clock.
 * Assumes small MEM_BITS and a 20-cycle hold-off.
 */
`default_nettype none

module serial_config_bitstream_source_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int NB = 16; // Stored bits per source
	localparam logic [15:0] PAT = 16'hc5a3; // First image
	localparam logic [15:0] P2 = 16'h3a5c; // Second image, inverse
	logic sys_clk, reset, load_en, load_bit, start;
	logic [3:0] load_addr;
	logic rx_valid, rx_bit, busy, config_done, por_busy, sent_all;
	logic sending_b, sent_all_b; // Status of the second source
	logic [15:0] rx_word; // Bits gathered from the target
	int rx_cnt, mismatches, samples_checked, cycles;
	scb_link_if lk();
	scb_link_if lk2();

	scb_device #(.MEM_BITS(NB), .POR_CYCLES(20)) scb_device_inst (
		.sys_clk(sys_clk), .reset(reset), .link(lk.dev),
		.load_en(load_en), .load_addr(load_addr), .load_bit(load_bit),
		.por_busy(por_busy), .sending(), .sent_all(sent_all));
	// Cascade left out to see the handoff stay idle
	scb_device #(.MEM_BITS(NB), .POR_CYCLES(20), .CASCADE_EN(1'b0))
		scb_device_inst_b (.sys_clk(sys_clk), .reset(reset),
		.link(lk2.dev), .load_en(load_en), .load_addr(load_addr),
		.load_bit(load_bit), .por_busy(), .sending(sending_b),
		.sent_all(sent_all_b));
	scb_target #(.TOTAL_BITS(NB)) scb_target_inst (.sys_clk(sys_clk),
		.reset(reset), .link(lk.tgt), .start(start), .rx_valid(rx_valid),
		.rx_bit(rx_bit), .busy(busy), .config_done(config_done));
	scb_props #(.MEM_BITS(NB)) scb_props_inst (.sys_clk(sys_clk),
		.reset(reset), .shift_clock(lk.shift_clock),
		.chip_select_n(lk.chip_select_n),
		.cascade_select_n(lk.cascade_select_n),
		.dev_oe_out(lk.dev_oe_out), .dev_oe_en(lk.dev_oe_en),
		.data_out(lk.data_out), .data_en(lk.data_en),
		.oe_level(lk.oe_level));

	// 250 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// Gather received bits, lowest first
	always @(posedge sys_clk) begin
		if (rx_valid === 1'b1) begin
			rx_word[rx_cnt[3:0]] <= rx_bit;
			rx_cnt <= rx_cnt + 1;
		end
	end

	// Hang guard, well above the whole run
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			wrap_up();
		end
	end

	task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic cyc(int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// Write an image into both sources
	task automatic load(logic [15:0] v);
		for (int i = 0; i < NB; i++) begin
			load_en = 1'b1;
			load_addr = 4'(i);
			load_bit = v[i];
			cyc(1);
		end
		load_en = 1'b0;
	endtask

	// Read the whole stream through the target
	task automatic run_cfg();
		rx_cnt = 0;
		start = 1'b1;
		cyc(1);
		start = 1'b0;
		cyc(3);
		chk("busy", busy, 1);
		// Mid-stream the target itself holds the line high
		cyc(40);
		chk("driven high", {lk.tgt_oe_en, lk.tgt_oe_out}, 16'h3);
		for (int i = 0; i < 3000 && busy !== 1'b0; i++) cyc(1);
		cyc(8);
	endtask

	// Bench-made shift clock rises on the second link, 32 ns period
	task automatic rise2(int n);
		repeat (n) begin
			lk2.shift_clock = 1'b1;
			cyc(4);
			lk2.shift_clock = 1'b0;
			cyc(4);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		reset = 1'b1;
		{load_en, load_bit, start, load_addr} = '0;
		{rx_cnt, mismatches, samples_checked, cycles} = '0;
		lk2.shift_clock = 1'b0;
		lk2.chip_select_n = 1'b1;
		lk2.tgt_oe_en = 1'b0;
		lk2.tgt_oe_out = 1'b1;
		cyc(10);
		reset = 1'b0;
		cyc(1);
		chk("por_busy", por_busy, 1);
		chk("oe held", lk.oe_level, 0);
		load(PAT);
		cyc(20);
		chk("por_busy", por_busy, 0);
		$display("test power-on done");
		run_cfg();
		chk("stream", rx_word, PAT);
		chk("bits", 16'(rx_cnt), 16'(NB));
		chk("cascade", lk.cascade_select_n, 0);
		chk("data_en", lk.data_en, 0);
		chk("sent_all", sent_all, 1);
		chk("config_done", config_done, 1);
		$display("test stream done");
		load(P2);
		run_cfg();
		chk("stream2", rx_word, P2);
		chk("no hold-off", por_busy, 0);
		$display("test reconfigure done");
		rise2(2);
		chk("deselected", lk2.data_en, 0);
		// First source has finished: its cascade output selects the next
		lk2.chip_select_n = lk.cascade_select_n;
		chk("handoff", lk2.chip_select_n, 0);
		cyc(8);
		chk("bit0", lk2.target_serial_input, P2[0]);
		chk("sending", sending_b, 1);
		rise2(3);
		chk("bit3", lk2.target_serial_input, P2[3]);
		lk2.tgt_oe_en = 1'b1;
		lk2.tgt_oe_out = 1'b0;
		cyc(25);
		chk("line low", lk2.data_en, 0);
		lk2.tgt_oe_en = 1'b0;
		cyc(8);
		chk("restart", lk2.target_serial_input, P2[0]);
		rise2(NB - 1);
		chk("last", lk2.target_serial_input, P2[NB-1]);
		rise2(2);
		chk("no cascade", lk2.cascade_select_n, 1);
		chk("released", lk2.data_en, 0);
		chk("pulled up", lk2.target_serial_input, 1);
		chk("stopped", sending_b, 0);
		chk("sent_all_b", sent_all_b, 1);
		$display("test direct link done");
		wrap_up();
	end
endmodule // serial_config_bitstream_source_tb

`default_nettype wire
